// ==== rtl/chan_eq_pkg.sv ====
// Purpose: constants for the channel equalizer/status register slice
// Assumes: 8-bit registers, byte addresses as printed
// Notes:   shared by the register bank and its eq_setting_table leaf module
package chan_eq_pkg;
  // ---------------------------------------------------------------
  // addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RSVD_A     = 8'h3F;
  localparam logic [7:0] ADDR_TABLE_BASE = 8'h40;
  localparam logic [7:0] ADDR_TABLE_LAST = 8'h4F;
  localparam logic [7:0] ADDR_SLICER     = 8'h50;
  localparam logic [7:0] ADDR_RSVD_B     = 8'h51;
  localparam logic [7:0] ADDR_BOOST      = 8'h52;
  localparam logic [7:0] ADDR_RSVD_C     = 8'h53;
  localparam logic [7:0] ADDR_OBSERVE    = 8'h54;
  localparam logic [7:0] ADDR_OPTION     = 8'h55;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int         TABLE_DEPTH     = 16;
  localparam int         TABLE_IDX_W     = 4;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam int         SLC_SIGN_BIT    = 4;
  localparam logic [7:0] SLC_MASK        = 8'h1F;
  localparam logic [3:0] SLC_MAX_STEP    = 4'hA;
  localparam int         MV_PER_STEP     = 5;
  localparam int         SLC_MV_W        = 6;
  localparam int         OBS_SD_BIT      = 7;
  localparam int         OBS_LIMIT_BIT   = 6;
  localparam int         OBS_LOCK_IRQ    = 1;
  localparam int         OBS_SD_IRQ      = 0;
  localparam int         OPT_ALT_FOM_BIT = 4;
  localparam int         OPT_SUBRATE_BIT = 0;
  localparam logic [7:0] OPT_MASK        = 8'h11;
  localparam logic [7:0] OPT_EEPROM_MASK = 8'h01;
endpackage : chan_eq_pkg

// ==== rtl/eq_setting_table.sv ====
// Purpose: sixteen-entry equalizer setting table in flip-flops
// Assumes: one write port, two combinational read ports
// Notes:   entries have no documented reset; cleared to zero
`timescale 1ns/1ps
`default_nettype none
module eq_setting_table #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             wr_i,
  input  wire logic [IDX_W-1:0] wr_idx_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic [IDX_W-1:0] rd_a_idx_i,
  output logic      [7:0]       rd_a_data_o,
  input  wire logic [IDX_W-1:0] rd_b_idx_i,
  output logic      [7:0]       rd_b_data_o
);
  initial begin
    if (DEPTH != (1 << IDX_W)) $error("table depth must be 2**IDX_W");
  end

  logic [7:0] entry_reg [DEPTH];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        entry_reg[i] <= chan_eq_pkg::RESET_BYTE;
      end else if (wr_i && (wr_idx_i == IDX_W'(i))) begin
        entry_reg[i] <= wr_data_i;
      end
    end
  end

  assign rd_a_data_o = entry_reg[rd_a_idx_i];
  assign rd_b_data_o = entry_reg[rd_b_idx_i];
endmodule : eq_setting_table
`default_nettype wire

// ==== rtl/event_flag.sv ====
// Purpose: sticky flag set on a rising event while enabled
// Assumes: event level synchronous to sys_clk_i
// Notes:   a set in the clear cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module event_flag (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic event_i,
  input  wire logic enable_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  logic prev_reg;
  logic flag_reg;
  logic set;

  assign set = enable_i && event_i && !prev_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= event_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= set || (flag_reg && !clear_i);
    end
  end

  assign flag_o = flag_reg;
endmodule : event_flag
`default_nettype wire

// ==== rtl/retimer_channel_eq_status_regs.sv ====
// Purpose: channel registers reserved_ctl_a..adapt_option_ctl: eq table, slicer, status
// Assumes: host and eeprom write ports synchronous to sys_clk_i
// Notes:   read data registered, one cycle after the read strobe
//
// Contract
// [R1] slicer offset is magnitude times 5 mV, signed
// [R2] software keeps slicer magnitude at ten or less
// [R3] boost readback shows equalizer boost in use
// [R4] observe bit 7 is live signal detect
// [R5] observe bit 6 is stage four limit bit
// [R6] option bit 4 selects alternate eye metric
// [R7] option bit 0 enables sub-rate adaptation
// [R8] sixteen writable, eeprom-loadable eq table entries
// [R9] interrupt flags raise only when enabled
// [R10] reserved bits read default, writes ignored
`timescale 1ns/1ps
`default_nettype none
module retimer_channel_eq_status_regs #(
  parameter int DEPTH = chan_eq_pkg::TABLE_DEPTH,
  parameter int IDX_W = chan_eq_pkg::TABLE_IDX_W
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  input  wire logic             eeprom_wr_i,
  input  wire logic [7:0]       eeprom_addr_i,
  input  wire logic [7:0]       eeprom_data_i,
  input  wire logic             sig_detect_i,
  input  wire logic             cdr_lock_i,
  input  wire logic             lock_irq_en_i,
  input  wire logic             sd_irq_en_i,
  input  wire logic [7:0]       boost_in_use_i,
  input  wire logic             eq_stage_four_limit_bit_i,
  input  wire logic [IDX_W-1:0] adapt_idx_i,
  output logic      [7:0]       adapt_eq_setting_o,
  output logic                  slicer_sign_o,
  output logic      [5:0]       slicer_offset_mv_o,
  output logic                  alt_eye_quality_metric_o,
  output logic                  subrate_adapt_en_o
);
  initial begin
    if (DEPTH != chan_eq_pkg::TABLE_DEPTH) $error("table spans adapt_eq_setting_table");
    if (IDX_W != chan_eq_pkg::TABLE_IDX_W) $error("index width must be 4");
  end

  // ---------------------------------------------------------------
  // write port merge: host has priority over eeprom load
  // ---------------------------------------------------------------
  logic       wr_en;
  logic       wr_from_host;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_table;

  assign wr_from_host = reg_wr_i;
  assign wr_en        = reg_wr_i || eeprom_wr_i;
  assign wr_addr      = reg_wr_i ? reg_addr_i : eeprom_addr_i;
  assign wr_data      = reg_wr_i ? reg_wdata_i : eeprom_data_i;
  assign wr_table     = wr_en && (wr_addr >= chan_eq_pkg::ADDR_TABLE_BASE)
                        && (wr_addr <= chan_eq_pkg::ADDR_TABLE_LAST);

  // ---------------------------------------------------------------
  // equalizer setting table
  // ---------------------------------------------------------------
  logic [7:0] table_rd_data;

  eq_setting_table #(
    .DEPTH (DEPTH),
    .IDX_W (IDX_W)
  ) u_table (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .wr_i        (wr_table),                 // R8
    .wr_idx_i    (wr_addr[IDX_W-1:0]),
    .wr_data_i   (wr_data),
    .rd_a_idx_i  (reg_addr_i[IDX_W-1:0]),
    .rd_a_data_o (table_rd_data),
    .rd_b_idx_i  (adapt_idx_i),
    .rd_b_data_o (adapt_eq_setting_o)
  );

  // ---------------------------------------------------------------
  // slicer offset control
  // ---------------------------------------------------------------
  logic [7:0] slicer_reg;
  logic [3:0] slicer_step;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slicer_reg <= chan_eq_pkg::RESET_BYTE;
    end else if (wr_en && (wr_addr == chan_eq_pkg::ADDR_SLICER)) begin
      slicer_reg <= wr_data & chan_eq_pkg::SLC_MASK; // R10
    end
  end

  // clamp keeps the output in range if software oversteps
  assign slicer_step = (slicer_reg[3:0] > chan_eq_pkg::SLC_MAX_STEP) ?
                       chan_eq_pkg::SLC_MAX_STEP : slicer_reg[3:0];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slicer_offset_mv_o <= '0;
      slicer_sign_o      <= 1'b0;
    end else begin
      slicer_offset_mv_o <= 6'(slicer_step * chan_eq_pkg::MV_PER_STEP); // R1
      slicer_sign_o      <= slicer_reg[chan_eq_pkg::SLC_SIGN_BIT]; // R1
    end
  end

  // ---------------------------------------------------------------
  // adaptation option control
  // ---------------------------------------------------------------
  logic [7:0] option_reg;
  logic [7:0] option_wmask;

  // eeprom load cannot touch the alternate metric select
  assign option_wmask = wr_from_host ? chan_eq_pkg::OPT_MASK :
                        chan_eq_pkg::OPT_EEPROM_MASK;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      option_reg <= chan_eq_pkg::RESET_BYTE;
    end else if (wr_en && (wr_addr == chan_eq_pkg::ADDR_OPTION)) begin
      option_reg <= (option_reg & ~option_wmask) | (wr_data & option_wmask); // R10
    end
  end

  assign alt_eye_quality_metric_o = option_reg[chan_eq_pkg::OPT_ALT_FOM_BIT]; // R6
  assign subrate_adapt_en_o       = option_reg[chan_eq_pkg::OPT_SUBRATE_BIT]; // R7

  // ---------------------------------------------------------------
  // interrupt flags, cleared by a host read of the observe register
  // ---------------------------------------------------------------
  logic obs_clear;
  logic lock_flag;
  logic sd_flag;

  assign obs_clear = reg_rd_i && (reg_addr_i == chan_eq_pkg::ADDR_OBSERVE);

  event_flag u_lock_flag (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .event_i   (cdr_lock_i),
    .enable_i  (lock_irq_en_i),              // R9
    .clear_i   (obs_clear),
    .flag_o    (lock_flag)
  );

  event_flag u_sd_flag (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .event_i   (sig_detect_i),
    .enable_i  (sd_irq_en_i),                // R9
    .clear_i   (obs_clear),
    .flag_o    (sd_flag)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = chan_eq_pkg::RESET_BYTE;
    if ((reg_addr_i >= chan_eq_pkg::ADDR_TABLE_BASE) &&
        (reg_addr_i <= chan_eq_pkg::ADDR_TABLE_LAST)) begin
      rd_mux = table_rd_data;
    end else begin
      case (reg_addr_i)
        chan_eq_pkg::ADDR_SLICER:  rd_mux = slicer_reg;
        chan_eq_pkg::ADDR_BOOST:   rd_mux = boost_in_use_i; // R3
        chan_eq_pkg::ADDR_OBSERVE: begin
          rd_mux[chan_eq_pkg::OBS_SD_BIT]    = sig_detect_i; // R4
          rd_mux[chan_eq_pkg::OBS_LIMIT_BIT] = eq_stage_four_limit_bit_i; // R5
          rd_mux[chan_eq_pkg::OBS_LOCK_IRQ]  = lock_flag;
          rd_mux[chan_eq_pkg::OBS_SD_IRQ]    = sd_flag;
        end
        chan_eq_pkg::ADDR_OPTION:  rd_mux = option_reg;
        default:                   rd_mux = chan_eq_pkg::RESET_BYTE; // R10
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= chan_eq_pkg::RESET_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_slicer_mv_step: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    $past(slicer_reg[3:0]) <= chan_eq_pkg::SLC_MAX_STEP |->
    slicer_offset_mv_o == 6'($past(slicer_reg[3:0]) * chan_eq_pkg::MV_PER_STEP))
    else $error("slicer offset not five mV per step");

  a_slicer_sign: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    (wr_en && wr_addr == chan_eq_pkg::ADDR_SLICER) |-> ##2
    slicer_sign_o == $past(wr_data[chan_eq_pkg::SLC_SIGN_BIT], 2))
    else $error("slicer sign not following write");

  a_boost_readback: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R3
    (reg_rd_i && reg_addr_i == chan_eq_pkg::ADDR_BOOST) |=>
    reg_rdata_o == $past(boost_in_use_i))
    else $error("boost readback mismatch");

  a_observe_live: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R4
    (reg_rd_i && reg_addr_i == chan_eq_pkg::ADDR_OBSERVE) |=>
    reg_rdata_o[chan_eq_pkg::OBS_SD_BIT] == $past(sig_detect_i))
    else $error("observe bit 7 not signal detect");

  a_observe_limit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
    (reg_rd_i && reg_addr_i == chan_eq_pkg::ADDR_OBSERVE) |=>
    reg_rdata_o[chan_eq_pkg::OBS_LIMIT_BIT] == $past(eq_stage_four_limit_bit_i))
    else $error("observe bit 6 not limit bit");

  a_alt_metric_sel: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
    (reg_wr_i && reg_addr_i == chan_eq_pkg::ADDR_OPTION) |=>
    alt_eye_quality_metric_o == $past(reg_wdata_i[chan_eq_pkg::OPT_ALT_FOM_BIT]))
    else $error("alternate metric select not written");

  a_subrate_enable: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R7
    (wr_en && wr_addr == chan_eq_pkg::ADDR_OPTION) |=>
    subrate_adapt_en_o == $past(wr_data[chan_eq_pkg::OPT_SUBRATE_BIT]))
    else $error("sub-rate enable not written");

  a_table_store: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R8
    (wr_table && !reg_rd_i ##1 reg_rd_i && !wr_en && reg_addr_i == $past(wr_addr))
    |=> reg_rdata_o == $past(wr_data, 2))
    else $error("table entry not stored");

  a_irq_gated: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (!lock_flag && !lock_irq_en_i) |=> !lock_flag)
    else $error("lock flag raised while disabled");

  a_irq_sd_gated: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (!sd_flag && !sd_irq_en_i) |=> !sd_flag)
    else $error("signal detect flag raised while disabled");

  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    (reg_rd_i && (reg_addr_i == chan_eq_pkg::ADDR_RSVD_A ||
     reg_addr_i == chan_eq_pkg::ADDR_RSVD_B || reg_addr_i == chan_eq_pkg::ADDR_RSVD_C))
    |=> reg_rdata_o == chan_eq_pkg::RESET_BYTE)
    else $error("reserved register not zero");

  // ---------------------------------------------------------------
  // checks: flag set and clear, slicer store, reserved bits, load port
  // ---------------------------------------------------------------
  a_lock_set_wins: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (lock_irq_en_i && cdr_lock_i && !$past(cdr_lock_i))
    |=> lock_flag)
    else $error("lock flag not set on enabled lock edge");

  a_sd_set_wins: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (sd_irq_en_i && sig_detect_i && !$past(sig_detect_i))
    |=> sd_flag)
    else $error("signal detect flag not set on enabled edge");

  a_lock_rd_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (obs_clear && !(lock_irq_en_i && cdr_lock_i && !$past(cdr_lock_i)))
    |=> !lock_flag)
    else $error("lock flag not cleared by observe read");

  a_sd_rd_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (obs_clear && !(sd_irq_en_i && sig_detect_i && !$past(sig_detect_i)))
    |=> !sd_flag)
    else $error("signal detect flag not cleared by observe read");

  a_observe_rsvd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    (reg_rd_i && reg_addr_i == chan_eq_pkg::ADDR_OBSERVE) |=>
    reg_rdata_o[chan_eq_pkg::OBS_LIMIT_BIT-1:chan_eq_pkg::OBS_LOCK_IRQ+1] == '0)
    else $error("observe reserved bits not zero");

  a_slicer_store: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    (wr_en && wr_addr == chan_eq_pkg::ADDR_SLICER) |=>
    slicer_reg == ($past(wr_data) & chan_eq_pkg::SLC_MASK))
    else $error("slicer register not written");

  a_slicer_rsvd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    (slicer_reg & ~chan_eq_pkg::SLC_MASK) == chan_eq_pkg::RESET_BYTE)
    else $error("slicer reserved bits not zero");

  a_option_rsvd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    (option_reg & ~chan_eq_pkg::OPT_MASK) == chan_eq_pkg::RESET_BYTE)
    else $error("option reserved bits not zero");

  a_load_alt_kept: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
    (eeprom_wr_i && !reg_wr_i && eeprom_addr_i == chan_eq_pkg::ADDR_OPTION)
    |=> $stable(alt_eye_quality_metric_o))
    else $error("eeprom load changed alternate metric select");
endmodule : retimer_channel_eq_status_regs
`default_nettype wire

// ==== test/eeprom_loader_model.sv ====
// Purpose: configuration eeprom model driving the load port
// Assumes: bench calls load_byte only after reset is released
// Notes:   address and data lines scrambled while the strobe is low
`timescale 1ns/1ps
`default_nettype none
module eeprom_loader_model (
  input  wire logic       sys_clk_i,
  output logic            eeprom_wr_o,
  output logic      [7:0] eeprom_addr_o,
  output logic      [7:0] eeprom_data_o
);
  initial begin
    eeprom_wr_o   = 1'b0;
    eeprom_addr_o = 8'h00;
    eeprom_data_o = 8'h00;
  end

  // one byte per strobe, held across the taking edge
  task automatic load_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    #1;
    eeprom_wr_o   = 1'b1;
    eeprom_addr_o = addr;
    eeprom_data_o = data;
    @(posedge sys_clk_i);
    #1;
    eeprom_wr_o   = 1'b0;
    eeprom_addr_o = ~addr;
    eeprom_data_o = ~data;
  endtask : load_byte
endmodule : eeprom_loader_model
`default_nettype wire

// ==== test/test_retimer_channel_eq_status_regs.sv ====
// Purpose: self-checking bench for the channel eq/status registers
// Assumes: strobe port, read data registered on the read edge
// Notes:   host and eeprom writes never share a cycle here
`timescale 1ns/1ps
`default_nettype none
module test_retimer_channel_eq_status_regs;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, boost_in_use_i = 8'h00;
  logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, sig_detect_i = 1'b0, cdr_lock_i = 1'b0;
  logic       lock_irq_en_i = 1'b0, sd_irq_en_i = 1'b0, limit_i = 1'b0;
  logic [3:0] adapt_idx_i = 4'h0;
  logic [7:0] reg_rdata_o, adapt_eq_setting_o, ee_addr, ee_data;
  logic [5:0] slicer_offset_mv_o;
  logic       slicer_sign_o, alt_o, sub_o, ee_wr;
  int         err_total = 0;
  int         n_compared = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  eeprom_loader_model u_rom (.sys_clk_i(sys_clk_i), .eeprom_wr_o(ee_wr),
    .eeprom_addr_o(ee_addr), .eeprom_data_o(ee_data));

  retimer_channel_eq_status_regs dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .eeprom_wr_i(ee_wr),
    .eeprom_addr_i(ee_addr), .eeprom_data_i(ee_data), .sig_detect_i(sig_detect_i),
    .cdr_lock_i(cdr_lock_i), .lock_irq_en_i(lock_irq_en_i), .sd_irq_en_i(sd_irq_en_i),
    .boost_in_use_i(boost_in_use_i), .eq_stage_four_limit_bit_i(limit_i),
    .adapt_idx_i(adapt_idx_i), .adapt_eq_setting_o(adapt_eq_setting_o),
    .slicer_sign_o(slicer_sign_o), .slicer_offset_mv_o(slicer_offset_mv_o),
    .alt_eye_quality_metric_o(alt_o), .subrate_adapt_en_o(sub_o));

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    cyc(1);
    reg_wr_i    = 1'b0;
  endtask : wr

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    cyc(1);
    reg_rd_i   = 1'b0;
    chk($sformatf("read %h", a), exp, reg_rdata_o);
  endtask : chk_rd

  // read taken on the edge right after the write edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    chk($sformatf("wr-rd %h", a), d, reg_rdata_o);
  endtask : wr_rd

  task automatic chk_slc(input logic s, input logic [5:0] mv);
    chk("slicer sign", {7'h00, s}, {7'h00, slicer_sign_o});
    chk("slicer mv", {2'b00, mv}, {2'b00, slicer_offset_mv_o});
  endtask : chk_slc

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a[7] = '{8'h3F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55};
    foreach (a[i]) chk_rd(a[i], 8'h00);
    chk_slc(1'b0, 6'd0);
    chk("option", 8'h00, {6'h00, alt_o, sub_o});
  endtask : t_reset

  task automatic t_table();
    for (int i = 0; i < 16; i++) wr(8'h40 + 8'(i), 8'h5A ^ 8'(i * 17));
    for (int i = 0; i < 16; i++) begin
      adapt_idx_i = 4'(i);
      chk_rd(8'h40 + 8'(i), 8'h5A ^ 8'(i * 17));
      chk("adapt entry", 8'h5A ^ 8'(i * 17), adapt_eq_setting_o);
    end
    wr_rd(8'h47, 8'h96);
  endtask : t_table

  task automatic t_slicer();
    logic [7:0] w[5] = '{8'h1A, 8'h07, 8'hF5, 8'hE3, 8'h0A};
    logic [5:0] mv[5] = '{6'd50, 6'd35, 6'd25, 6'd15, 6'd50};
    foreach (w[i]) begin
      wr(8'h50, w[i]);
      cyc(2);
      chk_slc(w[i][4], mv[i]);
      chk_rd(8'h50, w[i] & 8'h1F);
    end
  endtask : t_slicer

  task automatic t_boost();
    boost_in_use_i = 8'hA5;
    chk_rd(8'h52, 8'hA5);
    boost_in_use_i = 8'h3C;
    wr(8'h52, 8'hFF);
    chk_rd(8'h52, 8'h3C);
  endtask : t_boost

  task automatic t_observe();
    sig_detect_i = 1'b1;
    cdr_lock_i   = 1'b1;
    limit_i      = 1'b1;
    cyc(3);
    chk_rd(8'h54, 8'hC0);
    {sig_detect_i, cdr_lock_i, limit_i} = 3'b000;
    lock_irq_en_i = 1'b1;
    cyc(2);
    chk_rd(8'h54, 8'h00);
    {sig_detect_i, cdr_lock_i} = 2'b11;
    cyc(3);
    chk_rd(8'h54, 8'h82);
    {sig_detect_i, cdr_lock_i, sd_irq_en_i} = 3'b001;
    cyc(2);
    sig_detect_i = 1'b1;
    limit_i      = 1'b1;
    cyc(3);
    wr(8'h54, 8'h00);
    chk_rd(8'h54, 8'hC1);
    chk_rd(8'h54, 8'hC0);
  endtask : t_observe

  task automatic t_option();
    logic [7:0] w[3] = '{8'hFF, 8'h10, 8'hEF};
    foreach (w[i]) begin
      wr(8'h55, w[i]);
      cyc(1);
      chk("alt metric", {7'h00, w[i][4]}, {7'h00, alt_o});
      chk("subrate", {7'h00, w[i][0]}, {7'h00, sub_o});
      chk_rd(8'h55, w[i] & 8'h11);
    end
  endtask : t_option

  task automatic t_reserved();
    logic [7:0] a[5] = '{8'h3F, 8'h51, 8'h53, 8'h60, 8'h00};
    foreach (a[i]) begin
      wr(a[i], 8'hFF);
      chk_rd(a[i], 8'h00);
    end
  endtask : t_reserved

  task automatic t_eeprom();
    wr(8'h55, 8'h00);
    u_rom.load_byte(8'h4F, 8'hC3);
    chk_rd(8'h4F, 8'hC3);
    u_rom.load_byte(8'h55, 8'hFF);
    chk_rd(8'h55, 8'h01);
    u_rom.load_byte(8'h50, 8'h19);
    cyc(2);
    chk_slc(1'b1, 6'd45);
    u_rom.load_byte(8'h51, 8'hFF);
    chk_rd(8'h51, 8'h00);
  endtask : t_eeprom

  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    #200us;
    err_total++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_table();
    t_slicer();
    t_boost();
    t_observe();
    t_option();
    t_reserved();
    t_eeprom();
    close_out();
  end
endmodule : test_retimer_channel_eq_status_regs
`default_nettype wire
